/* File: hw/tick_timer_pkg.sv */
// constants shared by the periodic tick timer
package tick_timer_pkg;
  localparam int RELOAD_WIDTH = 24;
  localparam logic [RELOAD_WIDTH-1:0] COUNT_ZERO = 24'h000000;
  localparam logic [RELOAD_WIDTH-1:0] COUNT_ONE = 24'h000001;
  localparam logic [RELOAD_WIDTH-1:0] RELOAD_RESET = 24'h000000;
endpackage

/* File: hw/tick_pending.sv */
// pending flag for the tick interrupt request
`timescale 1ns/10ps
`default_nettype none
module tick_pending
(
  input wire logic clk,
  input wire logic reset,
  input wire logic setPulse,
  input wire logic clearPulse,
  output logic pending
);
  logic pending_reg;
  logic pending_next;

  always_comb
  begin
    // set wins so a tick in the clearing cycle is not lost
    pending_next = pending_reg;
    if (clearPulse)
    begin
      pending_next = 1'b0;
    end
    if (setPulse)
    begin
      pending_next = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pending_reg <= 1'b0;
    end
    else
    begin
      pending_reg <= pending_next;
    end
  end

  assign pending = pending_reg;
endmodule
`default_nettype wire

/* File: hw/periodic_tick_timer.sv */
// periodic down-counting tick timer with interrupt request
`timescale 1ns/10ps
`default_nettype none
module periodic_tick_timer
  import tick_timer_pkg::*;
#(
  parameter int WIDTH = RELOAD_WIDTH
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic tickEnable,
  input wire logic tickIntEnable,
  input wire logic [WIDTH-1:0] reloadWriteData,
  input wire logic reloadWrite,
  input wire logic currentWrite,
  input wire logic handlerEntry,
  output logic [WIDTH-1:0] reloadValue,
  output logic [WIDTH-1:0] currentValue,
  output logic tickPulse,
  output logic tickIrq
);

  // package constants brought to the counter width
  localparam logic [WIDTH-1:0] ZERO_VALUE = WIDTH'(COUNT_ZERO);
  localparam logic [WIDTH-1:0] ONE_VALUE = WIDTH'(COUNT_ONE);
  localparam logic [WIDTH-1:0] RESET_VALUE = WIDTH'(RELOAD_RESET);

  // what the counter does on one clock
  typedef enum logic [1:0]
  {
    STEP_HOLD = 2'b00,
    STEP_DOWN = 2'b01,
    STEP_WRAP = 2'b10,
    STEP_CLEAR = 2'b11
  } step_e;

  logic [WIDTH-1:0] reload_reg;
  logic [WIDTH-1:0] reload_next;
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  logic tick_reg;
  logic tick_next;
  logic atZero;
  step_e stepNow;
  logic tickSet;
  logic pending;

  function automatic logic is_zero
  (
    input logic [WIDTH-1:0] value
  );
    return value == ZERO_VALUE;
  endfunction

  function automatic logic [WIDTH-1:0] count_less_one
  (
    input logic [WIDTH-1:0] value
  );
    // only called away from zero, so no borrow out
    return value - ONE_VALUE;
  endfunction

  // clear beats counting so a write in a running cycle still lands
  function automatic step_e decode_step
  (
    input logic clearReq,
    input logic runReq,
    input logic isZero
  );
    step_e step;
    step = STEP_HOLD;
    if (clearReq)
    begin
      step = STEP_CLEAR;
    end
    else if (runReq)
    begin
      if (isZero)
      begin
        step = STEP_WRAP;
      end
      else
      begin
        step = STEP_DOWN;
      end
    end
    // disabled: hold, nothing reloads on enable
    return step;
  endfunction

  function automatic logic wraps_now
  (
    input step_e step
  );
    return step == STEP_WRAP;
  endfunction

  function automatic logic [WIDTH-1:0] count_after
  (
    input step_e step,
    input logic [WIDTH-1:0] count,
    input logic [WIDTH-1:0] reload
  );
    logic [WIDTH-1:0] result;
    result = count;
    case (step)
      STEP_CLEAR:
      begin
        result = ZERO_VALUE;
      end
      STEP_WRAP:
      begin
        // reload as it stands; a write this cycle waits for the next wrap
        result = reload;
      end
      STEP_DOWN:
      begin
        result = count_less_one(count);
      end
      default:
      begin
        result = count;
      end
    endcase
    return result;
  endfunction

  // reload group
  always_comb
  begin
    reload_next = reload_reg;
    if (reloadWrite)
    begin
      reload_next = reloadWriteData;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      reload_reg <= RESET_VALUE;
    end
    else
    begin
      reload_reg <= reload_next;
    end
  end

  // step decode, shared by the count and tick groups
  always_comb
  begin
    atZero = is_zero(count_reg);
    stepNow = decode_step(currentWrite, tickEnable, atZero);
  end

  // count group
  always_comb
  begin
    count_next = count_after(stepNow, count_reg, reload_reg);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      count_reg <= ZERO_VALUE;
    end
    else
    begin
      count_reg <= count_next;
    end
  end

  // tick group: one pulse per wrap, so wraps are reload plus one apart
  always_comb
  begin
    tick_next = 1'b0;
    if (wraps_now(stepNow))
    begin
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tick_reg <= 1'b0;
    end
    else
    begin
      tick_reg <= tick_next;
    end
  end

  // a tick while masked is not remembered, so unmasking shows no stale request
  assign tickSet = tick_reg & tickIntEnable;

  tick_pending tick_pending_i
  (
    .clk(clk),
    .reset(reset),
    .setPulse(tickSet),
    .clearPulse(handlerEntry),
    .pending(pending)
  );

  // data outputs straight from the registers
  assign reloadValue = reload_reg;
  assign currentValue = count_reg;
  assign tickPulse = tick_reg;
  // masking hides the request but the pending flag survives
  assign tickIrq = pending & tickIntEnable;
endmodule
`default_nettype wire

/* File: sim/tick_timer_checker.sv */
// port assertions for the periodic tick timer
`timescale 1ns/10ps
`default_nettype none
module tick_timer_checker #(parameter int WIDTH = 24)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic tickEnable,
  input wire logic tickIntEnable,
  input wire logic reloadWrite,
  input wire logic currentWrite,
  input wire logic handlerEntry,
  input wire logic [WIDTH-1:0] reloadValue,
  input wire logic [WIDTH-1:0] currentValue,
  input wire logic tickPulse,
  input wire logic tickIrq
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire go = tickEnable & !currentWrite;
  wire z = currentValue == 0;
  tick_wrap_a: assert property (go & !reloadWrite & z |=> tickPulse & currentValue == reloadValue)
    else $error("no reload at wrap");
  count_down_a: assert property (go & !z |=> !tickPulse & currentValue == $past(currentValue) - 1)
    else $error("bad decrement");
  hold_off_a: assert property (!tickEnable & !currentWrite |=> $stable(currentValue) & !tickPulse)
    else $error("moved while off");
  write_clear_a: assert property (currentWrite |=> z)
    else $error("write did not clear");
  irq_mask_a: assert property (!tickIntEnable |-> !tickIrq)
    else $error("request while masked");
  irq_raise_a: assert property (tickPulse & tickIntEnable ##1 tickIntEnable |-> tickIrq)
    else $error("tick not requested");
  irq_clear_a: assert property (handlerEntry & !tickPulse |=> !tickIrq)
    else $error("request not cleared");
  irq_hold_a: assert property (tickIrq & !handlerEntry ##1 tickIntEnable |-> tickIrq)
    else $error("request lost");
endmodule
bind periodic_tick_timer tick_timer_checker #(.WIDTH(WIDTH)) tick_timer_checker_i (.*);
`default_nettype wire

/* File: sim/tick_core_model.sv */
// core side: enters the tick handler a little after the request
`timescale 1ns/10ps
`default_nettype none
module tick_core_model
(
  input wire logic clk,
  input wire logic reset,
  input wire logic tickIrq,
  output logic handlerEntry
);
  // slow on purpose so the request is seen standing
  logic [1:0] waitReg;
  always_ff @(posedge clk)
  begin
    if (reset || !tickIrq)
    begin
      waitReg <= 2'h0;
    end
    else
    begin
      waitReg <= waitReg + 2'h1;
    end
  end
  assign handlerEntry = waitReg == 2'h2;
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// directed bench for the periodic tick timer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk = 0, reset = 1, tickEnable = 0, tickIntEnable = 0, reloadWrite = 0;
  logic currentWrite = 0, handlerEntry, tickPulse, tickIrq;
  logic [23:0] reloadWriteData = '0, reloadValue, currentValue;
  int error_cnt = 0, n_tests = 0;
  always #20 clk = ~clk;
  periodic_tick_timer periodic_tick_timer_i
  (
    .clk(clk),
    .reset(reset),
    .tickEnable(tickEnable),
    .tickIntEnable(tickIntEnable),
    .reloadWriteData(reloadWriteData),
    .reloadWrite(reloadWrite),
    .currentWrite(currentWrite),
    .handlerEntry(handlerEntry),
    .reloadValue(reloadValue),
    .currentValue(currentValue),
    .tickPulse(tickPulse),
    .tickIrq(tickIrq)
  );
  tick_core_model tick_core_model_i
  (
    .clk(clk),
    .reset(reset),
    .tickIrq(tickIrq),
    .handlerEntry(handlerEntry)
  );
  task automatic chk(input string name, input logic [23:0] s, input logic [23:0] e);
    n_tests++;
    if (s !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, e, s);
    end
  endtask
  // c = enable, int enable, reload write, current write
  task apply(logic [3:0] c, logic [23:0] d, int n);
    {tickEnable, tickIntEnable, reloadWrite, currentWrite} = c;
    reloadWriteData = d;
    repeat (n) @(negedge clk);
  endtask
  task complete_run;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (400) @(posedge clk);
    error_cnt++;
    complete_run;
  end
  initial
  begin
    repeat (8) @(negedge clk);
    reset = 0;
    apply(4'h2, 24'h2, 1);
    apply(4'h1, '0, 1);
    chk("cleared count", currentValue, '0);
    apply(4'hC, '0, 1);
    chk("tick at wrap", {22'h0, tickPulse, 1'b0} | currentValue, 24'h2);
    apply(4'hC, '0, 3);
    chk("period", {21'h0, currentValue[1:0], tickPulse}, 24'h5);
    apply(4'h0, '0, 5);
    chk("held count", currentValue, 24'h2);
    apply(4'hA, '0, 1);
    chk("resumed count", currentValue, 24'h1);
    chk("new reload", reloadValue, 24'h0);
    apply(4'h8, '0, 2);
    chk("next reload", {currentValue[22:0], tickPulse}, 24'h1);
    apply(4'h8, '0, 1);
    chk("masked irq", {22'h0, tickIrq, tickPulse}, 24'h1);
    apply(4'h2, 24'hFFFFFF, 1);
    apply(4'h9, '0, 1);
    apply(4'h8, '0, 1);
    chk("longest period", currentValue, 24'hFFFFFF);
    apply(4'h2, 24'h1, 1);
    apply(4'h5, '0, 1);
    apply(4'hC, '0, 1);
    apply(4'h4, '0, 1);
    chk("raised irq", {23'h0, tickIrq}, 24'h1);
    chk("count in range", currentValue, 24'h1);
    apply(4'h4, '0, 2);
    chk("irq until handler", {23'h0, tickIrq}, 24'h1);
    apply(4'h4, '0, 1);
    chk("irq after handler", {23'h0, tickIrq}, 24'h0);
    apply(4'h8, '0, 1);
    chk("decrement", currentValue, 24'h0);
    complete_run;
  end
endmodule
`default_nettype wire
